// ===== bench/sd_proto_model.sv
// Protocol device model: presents transmit words on reference clock pulses.
`timescale 1ns/1ns
module sd_proto_model (
    output logic ref_clk_out,
    output logic [sd_pkg::SD_DATA_W-1:0] tx_data_out,
    output logic tx_k_lo_out,
    output logic tx_k_hi_out
);
    import sd_pkg::*;

    initial begin
        ref_clk_out = 1'b0;
        tx_data_out = 16'h0000;
        tx_k_lo_out = 1'b0;
        tx_k_hi_out = 1'b0;
    end

    // One 200 ns reference cycle per word, as long as the 200 ns serial slot,
    // so that the serial slot of the previous word is never overrun
    task automatic send_word(input logic [15:0] d, input logic klo, input logic khi);
        tx_data_out = d;
        tx_k_lo_out = klo;
        tx_k_hi_out = khi;
        #100;
        ref_clk_out = 1'b1;
        #63;
        ref_clk_out = 1'b0;
        #37;
    endtask : send_word
endmodule : sd_proto_model

// ===== bench/sd_serdes_tb_top.sv
// Testbench for the serdes core: power, serial code, loopback, lock, loss and test mode.
`timescale 1ns/1ns
module sd_serdes_tb_top;
    import sd_pkg::*;
    logic clk_in, rst_n_in, enable_in, loop_sel, lock_n, prbs_sel, loss_force;
    logic sin_p = 1'b0;
    logic ref_clk, k_lo, k_hi, sout_p, sout_n, sout_oe_n;
    logic rk_lo, rk_hi, rx_oe_n, rclk, rclk_oe_n, loss;
    logic [SD_DATA_W-1:0] tx_data, rx_data;
    logic [9:0] tx_sh = 10'h000;
    logic [15:0] wd [8] = '{16'h00bc, 16'h00bc, 16'h1234, 16'h1c55,
                            16'h0000, 16'hffff, 16'h1c1c, 16'h00bc};
    logic [1:0] wk [8] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0, 2'h3, 2'h1};
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int i, j;

    sd_proto_model sd_proto_model_i (.ref_clk_out(ref_clk), .tx_data_out(tx_data),
        .tx_k_lo_out(k_lo), .tx_k_hi_out(k_hi));

    sd_serdes #(.BIT_DIV(8'h01)) sd_serdes_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .enable_in(enable_in),
        .transmit_reference_clock_in(ref_clk), .tx_data_in(tx_data),
        .tx_low_byte_special_flag_in(k_lo), .tx_high_byte_special_flag_in(k_hi),
        .loopback_select_in(loop_sel), .lock_to_reference_n_in(lock_n),
        .pseudo_random_check_select_in(prbs_sel),
        .serial_in_positive_in(loss_force ? 1'b0 : sin_p),
        .serial_in_negative_in(loss_force ? 1'b0 : ~sin_p),
        .serial_out_positive_out(sout_p), .serial_out_negative_out(sout_n),
        .serial_out_oe_n_out(sout_oe_n), .receive_data_bus_out(rx_data),
        .rx_low_byte_special_flag_out(rk_lo), .rx_high_byte_special_flag_out(rk_hi),
        .rx_bus_oe_n_out(rx_oe_n), .recovered_receive_clock_out(rclk),
        .recovered_clock_oe_n_out(rclk_oe_n), .signal_loss_detect_out(loss));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Far-end line toggles every cycle so the receive pair looks dead only while loss_force is set
    always @(negedge clk_in) sin_p <= ~sin_p;
    always @(posedge clk_in) tx_sh <= {tx_sh[8:0], sout_p};

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk_bit(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic cycles_n(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cycles_n

    task automatic wait_rx(input logic [15:0] d, input logic klo, input logic khi);
        int n;
        for (n = 0; n < 120; n++) begin
            @(negedge clk_in);
            if (rx_data === d && rk_lo === klo && rk_hi === khi) break;
        end
        chk_word("rx word", d, rx_data);
        chk_bit("rx low flag", klo, rk_lo);
        chk_bit("rx high flag", khi, rk_hi);
        // Recovered clock falls with new data and is high again mid-word
        chk_bit("rx clock at new word", 1'b0, rclk);
        cycles_n(10);
        chk_bit("rx clock mid word", 1'b1, rclk);
    endtask : wait_rx

    // First bit sent sits in the top of the window
    task automatic wait_pattern(input logic [9:0] pat);
        int n;
        for (n = 0; n < 60; n++) begin
            @(negedge clk_in);
            if (tx_sh === pat) break;
        end
        chk_word("serial symbol", {6'h00, pat}, {6'h00, tx_sh});
        chk_bit("serial neg leg", ~sout_p, sout_n);
    endtask : wait_pattern

    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        rst_n_in = 1'b0;
        enable_in = 1'b1;
        loop_sel = 1'b0;
        lock_n = 1'b1;
        prbs_sel = 1'b0;
        loss_force = 1'b0;
        cycles_n(10);
        rst_n_in = 1'b1;
        cycles_n(50);
        chk_bit("rclk in por", 1'b0, rclk);
        chk_bit("serial oe_n in por", 1'b1, sout_oe_n);
        chk_bit("rx oe_n in por", 1'b1, rx_oe_n);
        cycles_n(70);
        chk_bit("serial oe_n run", 1'b0, sout_oe_n);
        chk_bit("rx oe_n run", 1'b0, rx_oe_n);
        // Comma in negative running disparity, first word after power-on
        fork
            sd_proto_model_i.send_word(16'h00bc, 1'b1, 1'b0);
            wait_pattern(10'b0011111010);
        join
        loop_sel = 1'b1;
        cycles_n(2);
        chk_bit("serial oe_n loop", 1'b1, sout_oe_n);
        fork
            for (i = 0; i < 8; i++) sd_proto_model_i.send_word(wd[i], wk[i][0], wk[i][1]);
            for (j = 2; j < 8; j++) wait_rx(wd[j], wk[j][0], wk[j][1]);
        join
        lock_n = 1'b0;
        cycles_n(4);
        chk_bit("rx oe_n lock", 1'b1, rx_oe_n);
        chk_bit("rclk oe_n lock", 1'b1, rclk_oe_n);
        lock_n = 1'b1;
        prbs_sel = 1'b1;
        for (i = 0; i < 400 && rk_lo !== 1'b1; i++) @(negedge clk_in);
        chk_bit("prbs pass", 1'b1, rk_lo);
        // Alternating far-end bits are not a valid sequence
        loop_sel = 1'b0;
        cycles_n(200);
        chk_bit("prbs fail", 1'b0, rk_lo);
        prbs_sel = 1'b0;
        chk_bit("loss idle", 1'b0, loss);
        loss_force = 1'b1;
        cycles_n(45);
        chk_bit("loss early", 1'b0, loss);
        cycles_n(15);
        chk_bit("loss set", 1'b1, loss);
        loss_force = 1'b0;
        cycles_n(8);
        chk_bit("loss clear", 1'b0, loss);
        loss_force = 1'b1;
        enable_in = 1'b0;
        cycles_n(60);
        chk_bit("serial oe_n off", 1'b1, sout_oe_n);
        chk_bit("rx oe_n off", 1'b1, rx_oe_n);
        chk_bit("rclk oe_n off", 1'b1, rclk_oe_n);
        chk_bit("loss while off", 1'b1, loss);
        loss_force = 1'b0;
        enable_in = 1'b1;
        cycles_n(20);
        chk_bit("rclk in por again", 1'b0, rclk);
        chk_bit("rx oe_n in por again", 1'b1, rx_oe_n);
        cycles_n(100);
        chk_bit("rx oe_n run again", 1'b0, rx_oe_n);
        report_and_stop();
    end
endmodule : sd_serdes_tb_top

// ===== hdl/sd_pkg.sv
// Shared constants, types and the 8b/10b symbol encoder for the serdes block.
package sd_pkg;

    localparam int SD_CLK_NS = 10;
    localparam int SD_DATA_W = 16;
    localparam int SD_WORD_BITS = 20;
    localparam int SD_SYM_BITS = 10;
    localparam int SD_POR_NS = 1000;
    localparam int SD_POR_CYCLES = (SD_POR_NS + SD_CLK_NS - 1) / SD_CLK_NS;
    localparam int SD_LOS_NS = 500;
    localparam int SD_LOS_CYCLES = (SD_LOS_NS + SD_CLK_NS - 1) / SD_CLK_NS;
    localparam int SD_PRBS_WIN = 63;
    localparam logic [6:0] SD_PRBS_SEED = 7'h7f;
    localparam logic [6:0] SD_COMMA_N = 7'h1f;
    localparam logic [6:0] SD_COMMA_P = 7'h60;
    localparam logic [4:0] SD_RX_COMMA_POS = 5'h07;
    localparam logic [4:0] SD_RX_LAST = 5'h13;
    localparam logic [4:0] SD_RX_HALF = 5'h0a;
    localparam logic [4:0] SD_TX_REST = 5'h13;
    localparam logic [5:0] SD_K28_6B = 6'h0f;
    localparam logic [3:0] SD_ALT4 = 4'h7;
    localparam logic [5:0] SD_TAB6 [32] = '{
        6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] SD_TAB4 [8] = '{
        4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

    typedef enum logic [1:0] {SD_OFF, SD_POR, SD_RUN} sd_pwr_t;

    // Returns {disparity after symbol, abcdei fghj}; bit 9 is sent first
    function automatic logic [10:0] sd_encode(input logic k, input logic [7:0] d,
                                              input logic rd);
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] c6;
        logic [3:0] c4;
        logic r1;
        logic alt;
        x = d[4:0];
        y = d[7:5];
        c6 = SD_TAB6[x];
        c4 = SD_TAB4[y];
        if (k && x == 5'h1c) begin
            // Built in negative-disparity form, inverted whole below if needed
            c6 = SD_K28_6B;
            r1 = 1'b1;
            alt = (y == 3'h7);
        end else begin
            if (rd && (($countones(c6) != 3) || x == 5'h07)) c6 = ~c6;
            r1 = ($countones(c6) == 3) ? rd : ~rd;
            alt = (y == 3'h7) && (k || (!r1 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
                  || (r1 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
        end
        if (alt) c4 = SD_ALT4;
        if (r1 && (($countones(c4) != 2) || y == 3'h3)) c4 = ~c4;
        if (k && x == 5'h1c && rd) begin
            c6 = ~c6;
            c4 = ~c4;
        end
        return {($countones({c6, c4}) == 5) ? rd : ~rd, c6, c4};
    endfunction : sd_encode

endpackage : sd_pkg

// ===== hdl/sd_serdes.sv
// Serdes core: 8b/10b transmit, serialiser, deserialiser, decoder and power control.
`timescale 1ns/1ns
module sd_serdes #(
    parameter logic [7:0] BIT_DIV = 8'h01
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic transmit_reference_clock_in,
    input wire logic [sd_pkg::SD_DATA_W-1:0] tx_data_in,
    input wire logic tx_low_byte_special_flag_in,
    input wire logic tx_high_byte_special_flag_in,
    input wire logic loopback_select_in,
    input wire logic lock_to_reference_n_in,
    input wire logic pseudo_random_check_select_in,
    input wire logic serial_in_positive_in,
    input wire logic serial_in_negative_in,
    output logic serial_out_positive_out,
    output logic serial_out_negative_out,
    output logic serial_out_oe_n_out,
    output logic [sd_pkg::SD_DATA_W-1:0] receive_data_bus_out,
    output logic rx_low_byte_special_flag_out,
    output logic rx_high_byte_special_flag_out,
    output logic rx_bus_oe_n_out,
    output logic recovered_receive_clock_out,
    output logic recovered_clock_oe_n_out,
    output logic signal_loss_detect_out
);
    import sd_pkg::*;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic [17:0] tx_in_s;
    logic [6:0] ctl_s;
    logic ref_s, en_s, loop_s, lock_s, prbs_s, sin_p_s, sin_n_s;
    logic ref_q, ref_rise;
    sd_pwr_t state;
    logic [11:0] por_cnt;
    logic run, rx_en;
    logic [7:0] div_cnt;
    logic bit_tick;

    sd_sync2 #(.WIDTH(18)) u_tx_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in({tx_high_byte_special_flag_in, tx_low_byte_special_flag_in, tx_data_in}),
        .sync_out(tx_in_s)
    );
    sd_sync2 #(.WIDTH(7)) u_ctl_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in({transmit_reference_clock_in, enable_in, loopback_select_in,
                   lock_to_reference_n_in, pseudo_random_check_select_in,
                   serial_in_positive_in, serial_in_negative_in}),
        .sync_out(ctl_s)
    );
    assign {ref_s, en_s, loop_s, lock_s, prbs_s, sin_p_s, sin_n_s} = ctl_s;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) ref_q <= 1'b0;
        else ref_q <= ref_s;
    end
    assign ref_rise = ref_s && !ref_q;

    // Power control; coming out of reset with enable high also passes through reset
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= SD_OFF;
            por_cnt <= '0;
        end else begin
            case (state)
                SD_OFF: begin
                    por_cnt <= '0;
                    if (en_s) state <= SD_POR;
                end
                SD_POR: begin
                    por_cnt <= por_cnt + 12'h001;
                    if (!en_s) state <= SD_OFF;
                    else if (por_cnt == 12'(SD_POR_CYCLES - 1)) state <= SD_RUN;
                end
                SD_RUN: if (!en_s) state <= SD_OFF;
                default: state <= SD_OFF;
            endcase
        end
    end
    assign run = (state == SD_RUN);
    assign rx_en = run && lock_s;

    AST_ENABLE_RESET: assert property (state == SD_OFF && en_s |=> state == SD_POR)
        else $error("enable rise did not start power-on reset");
    AST_POWER_DOWN: assert property (!en_s |=> state == SD_OFF)
        else $error("enable low did not power down");

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !run || div_cnt == BIT_DIV - 8'h01) div_cnt <= '0;
        else div_cnt <= div_cnt + 8'h01;
    end
    assign bit_tick = run && (div_cnt == BIT_DIV - 8'h01);

    // Transmit side
    logic [15:0] tx_word;
    logic [1:0] tx_k;
    logic tx_pend, tx_rd, tx_load;
    logic [19:0] tx_sh;
    logic [4:0] tx_cnt;
    logic [6:0] prbs_gen;
    logic [10:0] enc_lo, enc_hi;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !run) begin
            tx_word <= '0;
            tx_k <= '0;
        end else if (ref_rise) begin
            tx_word <= tx_in_s[15:0];
            tx_k <= tx_in_s[17:16];
        end
    end

    assign enc_lo = sd_encode(tx_k[0], tx_word[7:0], tx_rd);
    assign enc_hi = sd_encode(tx_k[1], tx_word[15:8], enc_lo[10]);
    assign tx_load = bit_tick && tx_cnt == 5'h00 && tx_pend;

    // A word captured while the previous one is still pending replaces it
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !run) tx_pend <= 1'b0;
        else if (ref_rise) tx_pend <= 1'b1;
        else if (tx_load) tx_pend <= 1'b0;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !run) begin
            tx_sh <= '0;
            tx_cnt <= '0;
            tx_rd <= 1'b0;
            prbs_gen <= SD_PRBS_SEED;
            serial_out_positive_out <= 1'b0;
            serial_out_negative_out <= 1'b1;
        end else if (bit_tick && prbs_s) begin
            prbs_gen <= {prbs_gen[5:0], prbs_gen[6] ^ prbs_gen[5]};
            serial_out_positive_out <= prbs_gen[6] ^ prbs_gen[5];
            serial_out_negative_out <= ~(prbs_gen[6] ^ prbs_gen[5]);
        end else if (tx_load) begin
            // First bit leaves on the load tick so words follow with no gap
            tx_sh <= {enc_lo[8:0], enc_hi[9:0], 1'b0};
            tx_cnt <= SD_TX_REST;
            tx_rd <= enc_hi[10];
            serial_out_positive_out <= enc_lo[9];
            serial_out_negative_out <= ~enc_lo[9];
        end else if (bit_tick && tx_cnt != 5'h00) begin
            tx_sh <= {tx_sh[18:0], 1'b0};
            tx_cnt <= tx_cnt - 5'h01;
            serial_out_positive_out <= tx_sh[19];
            serial_out_negative_out <= ~tx_sh[19];
        end
    end

    AST_TX_CAPTURE: assert property (run && ref_rise |=> tx_word == $past(tx_in_s[15:0]))
        else $error("transmit word not captured on reference edge");
    AST_TX_ENCODE: assert property (tx_load && !prbs_s |=>
        serial_out_positive_out == $past(enc_lo[9]) && tx_rd == $past(enc_hi[10]))
        else $error("encoded word not loaded");
    sequence s_tx_load;
        tx_load && !prbs_s;
    endsequence
    sequence s_three_ticks;
        (run && bit_tick && !prbs_s)[*3];
    endsequence
    AST_TX_SERIAL: assert property (s_tx_load ##1 s_three_ticks |-> tx_cnt == 5'h11)
        else $error("serial bit count wrong");

    assign serial_out_oe_n_out = !(run && !loop_s);
    AST_LOOP_HIZ: assert property (loop_s |-> serial_out_oe_n_out)
        else $error("serial output driven in loopback");

    // Receive side
    logic rx_b, comma, rx_done, rx_rd;
    logic [19:0] rx_sh;
    logic [4:0] rx_cnt;
    logic [1:0] rx_k;
    logic [10:0] dec_lo, dec_hi;
    logic [6:0] prbs_chk;
    logic [5:0] prbs_good;
    logic prbs_ok;
    logic [11:0] los_cnt;

    // Returns {found, control, disparity after, byte}; searches the encoder
    function automatic logic [10:0] sd_decode(input logic [9:0] sym);
        logic [10:0] res;
        logic [10:0] e;
        logic [8:0] c;
        logic kv;
        res = '0;
        for (int i = 0; i < 512; i++) begin
            c = i[8:0];
            kv = c[4:0] == 5'h1c || (c[7:5] == 3'h7 && (c[4:0] == 5'h17 ||
                 c[4:0] == 5'h1b || c[4:0] == 5'h1d || c[4:0] == 5'h1e));
            for (int r = 0; r < 2; r++) begin
                e = sd_encode(c[8], c[7:0], r[0]);
                if (e[9:0] == sym && (!c[8] || kv)) res = {1'b1, c[8], e[10], c[7:0]};
            end
        end
        return res;
    endfunction : sd_decode

    assign rx_b = loop_s ? serial_out_positive_out : sin_p_s;
    assign comma = ({rx_sh[5:0], rx_b} == SD_COMMA_N) || ({rx_sh[5:0], rx_b} == SD_COMMA_P);
    assign dec_lo = sd_decode(rx_sh[19:10]);
    assign dec_hi = sd_decode(rx_sh[9:0]);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !rx_en) begin
            rx_sh <= '0;
            rx_cnt <= '0;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (bit_tick) begin
                rx_sh <= {rx_sh[18:0], rx_b};
                if (comma) rx_cnt <= SD_RX_COMMA_POS;
                else if (rx_cnt == SD_RX_LAST) begin
                    rx_cnt <= '0;
                    rx_done <= 1'b1;
                end else rx_cnt <= rx_cnt + 5'h01;
            end
        end
    end

    // Recovered clock falls as new data appears and rises mid-word
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !rx_en) begin
            recovered_receive_clock_out <= 1'b0;
            receive_data_bus_out <= '0;
            rx_k <= '0;
            rx_rd <= 1'b0;
        end else begin
            recovered_receive_clock_out <= (rx_cnt >= SD_RX_HALF);
            if (rx_done) begin
                receive_data_bus_out <= {dec_hi[7:0], dec_lo[7:0]};
                rx_k <= {dec_hi[9], dec_lo[9]};
                rx_rd <= dec_hi[8];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !rx_en) begin
            prbs_chk <= '0;
            prbs_good <= '0;
        end else if (bit_tick) begin
            prbs_chk <= {prbs_chk[5:0], rx_b};
            if (rx_b != (prbs_chk[6] ^ prbs_chk[5])) prbs_good <= '0;
            else if (prbs_good != 6'(SD_PRBS_WIN)) prbs_good <= prbs_good + 6'h01;
        end
    end
    assign prbs_ok = (prbs_good == 6'(SD_PRBS_WIN));

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_low_byte_special_flag_out <= 1'b0;
            rx_high_byte_special_flag_out <= 1'b0;
        end else begin
            rx_low_byte_special_flag_out <= prbs_s ? prbs_ok : rx_k[0];
            rx_high_byte_special_flag_out <= rx_k[1];
        end
    end

    // Amplitude loss is seen as both legs equal; runs even in power-down
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            los_cnt <= '0;
            signal_loss_detect_out <= 1'b0;
        end else begin
            if (sin_p_s != sin_n_s) los_cnt <= '0;
            else if (los_cnt != 12'(SD_LOS_CYCLES)) los_cnt <= los_cnt + 12'h001;
            signal_loss_detect_out <= (los_cnt == 12'(SD_LOS_CYCLES));
        end
    end

    assign rx_bus_oe_n_out = !rx_en;
    assign recovered_clock_oe_n_out = !(state != SD_OFF && lock_s);

    AST_RX_WORD: assert property (rx_en && bit_tick && rx_cnt == SD_RX_LAST && !comma
        |=> rx_done)
        else $error("20-bit word not completed");
    AST_RX_DATA: assert property (rx_en && rx_done ##1 rx_en |->
        receive_data_bus_out == {$past(dec_hi[7:0]), $past(dec_lo[7:0])})
        else $error("decoded data not presented");
    AST_LOOP_PATH: assert property (rx_en && loop_s && bit_tick ##1 rx_en |->
        rx_sh[0] == $past(serial_out_positive_out))
        else $error("loopback bit not received");
    AST_LOS: assert property (los_cnt == 12'(SD_LOS_CYCLES) |=> signal_loss_detect_out)
        else $error("signal loss not reported");
    AST_LOS_CLEAR: assert property (sin_p_s != sin_n_s ##1 1'b1 |=> !signal_loss_detect_out)
        else $error("signal loss reported with valid input");
    AST_LOCK_HIZ: assert property (!lock_s |-> rx_bus_oe_n_out && recovered_clock_oe_n_out
        ##1 !recovered_receive_clock_out)
        else $error("receive outputs active with lock to reference low");
    AST_POR_QUIET: assert property (state == SD_POR |-> serial_out_oe_n_out && rx_bus_oe_n_out
        ##1 !recovered_receive_clock_out)
        else $error("outputs not quiet during power-on reset");
    AST_KFLAG: assert property (rx_en && rx_done && !prbs_s ##1 !prbs_s ##1 !prbs_s |->
        rx_low_byte_special_flag_out == $past(dec_lo[9], 2))
        else $error("low special flag wrong");
    AST_PRBS_FLAG: assert property (prbs_s ##1 prbs_s |->
        rx_low_byte_special_flag_out == $past(prbs_ok))
        else $error("test result not on low special flag");
endmodule : sd_serdes

// ===== hdl/sd_sync2.sv
// Two-flip-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ns
module sd_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : sd_sync2
